// file: inc/acr_pkg.sv
// constants, offsets and field layout of the auto-stop error / capability bank
// assumes a 16-bit register port with word addresses in bytes
package acr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  // byte offsets
  localparam logic [7:0] OFF_ASTOP_STATUS = 8'h3c;
  localparam logic [7:0] OFF_CAP_W0 = 8'h40;
  localparam logic [7:0] OFF_CAP_W1 = 8'h42;
  localparam logic [7:0] OFF_CAP_W2 = 8'h44;
  localparam logic [7:0] OFF_CAP_W3 = 8'h46;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h50;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h52;
  localparam logic [7:0] OFF_CAP_LOAD = 8'h54;
  // status field positions
  localparam int unsigned B_NOT_EXEC = 0;
  localparam int unsigned B_TIMEOUT = 1;
  localparam int unsigned B_CRC = 2;
  localparam int unsigned B_END = 3;
  localparam int unsigned B_INDEX = 4;
  localparam int unsigned B_NOT_ISSUED = 7;
  localparam logic [15:0] STATUS_MASK = 16'h009f;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  // capability field positions
  localparam int unsigned B_V33 = 24;
  localparam int unsigned B_V30 = 25;
  localparam int unsigned B_V18 = 26;
  localparam int unsigned B_BUS64 = 28;
  // readable capability bits; others read zero
  localparam logic [63:0] CAP_MASK = 64'h0000_0000_17eb_3fbf;
  localparam logic [63:0] CAP_RST = 64'h0000_0000_0000_0000;
  localparam logic [15:0] IRQ_MASK_RST = 16'h0000;
  // response timeout in card clocks
  localparam int unsigned RESP_TIMEOUT_CLKS = 64;
  localparam logic [6:0] RESP_TIMEOUT_CNT = 7'(RESP_TIMEOUT_CLKS);
  // interrupt status bits
  localparam int unsigned IRQ_ASTOP = 0;
  localparam int unsigned IRQ_CAP_DONE = 1;
  localparam logic [15:0] IRQ_USED = 16'h0003;
endpackage

// file: inc/acr_cap_if.sv
// capability image path between the bank and its store
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface acr_cap_if;
  logic load;
  logic [63:0] wdata;
  logic [63:0] rdata;
  modport store (input load, input wdata, output rdata);
  modport user (output load, output wdata, input rdata);
endinterface
`default_nettype wire

// file: hdl/acr_cap_store.sv
// registered store of the 64-bit capabilities word
// assumes loads come only from the bank's load sequence
`timescale 1ns/1ps
`default_nettype none
module acr_cap_store (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // image port
  acr_cap_if.store cap
);
  logic [63:0] img_q;
  logic [63:0] img_d;

  always_comb begin
    img_d = img_q;
    if (cap.load) begin
      img_d = cap.wdata & acr_pkg::CAP_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      img_q <= acr_pkg::CAP_RST;
    end else begin
      img_q <= img_d;
    end
  end

  assign cap.rdata = img_q;
endmodule
`default_nettype wire

// file: hdl/acr_regs.sv
// auto-stop error status, capabilities word and their interrupt
// assumes a synchronous register port and a command engine on ref_clk
// Summary of operation
// - not-executed sets when a prior error blocks the stop, clears on issue.
// - a transfer that never started leaves not-executed clear.
// - while not-executed is set, bits 4..1 are meaningless to software.
// - crc and timeout together encode none, timeout, crc or line conflict.
// - at response end bit, each error bit 4..1 takes its detected value.
// - just before a status read, not-issued shows a waiting command while any of bits 4..1 is set.
// - not-issued is sampled only when the command register is not written.
// - any of bits 4..0 becoming set raises the auto-stop interrupt.
// - not-issued alone never raises the interrupt.
// - capabilities are fixed straps or loaded from nonvolatile memory.
// - a nonvolatile load is tied to the full software reset control.
// - bit 28 reads one only with 64-bit descriptors on a 64-bit bus; with USE_NVM the code takes nvm_data bit 28 and bus64 instead.
// - bits 24..26 report 3.3, 3.0, 1.8 V support, bit 27 reserved.
// - not-issued means a non-data command was dropped by a stop error.
// - timeout sets after a fixed count of card clocks with no response.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module acr_regs #(
  parameter int unsigned TIMEOUT_CLKS = acr_pkg::RESP_TIMEOUT_CLKS,
  parameter logic [63:0] CAP_FIXED = 64'h0000_0000_0100_0000,
  parameter bit USE_NVM = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // command engine events
  input wire logic stop_due,
  input wire logic prior_error,
  input wire logic xfer_started,
  input wire logic stop_issued,
  input wire logic card_clk_tick,
  input wire logic resp_end,
  input wire logic resp_crc_err,
  input wire logic resp_end_err,
  input wire logic resp_index_err,
  input wire logic non_data_command_pending,
  input wire logic cmd_reg_wr,
  // capability sources
  input wire logic addr64_desc,
  input wire logic bus64,
  input wire logic full_reset,
  input wire logic nvm_valid,
  input wire logic [63:0] nvm_data,
  // status out
  output logic cap_ready,
  output logic irq
);
  // counter is 7 bits wide and must start above zero
  if (TIMEOUT_CLKS < 1 || TIMEOUT_CLKS > 127) begin : g_bad_timeout
    $error("TIMEOUT_CLKS out of range");
  end

  typedef enum logic [1:0] {
    ACR_IDLE,
    ACR_WAIT_RESP
  } acr_state_t;

  typedef enum logic [1:0] {
    ACR_CAP_WAIT,
    ACR_CAP_LOAD,
    ACR_CAP_DONE
  } acr_cap_state_t;

  localparam logic [6:0] TO_CNT = 7'(TIMEOUT_CLKS);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  acr_cap_if cap ();

  acr_cap_store u_store (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .cap(cap)
  );

  acr_state_t st_q, st_d;
  acr_cap_state_t cst_q, cst_d;
  logic [15:0] status_q, status_d;
  logic [6:0] to_q, to_d;
  logic [15:0] ists_q, ists_d;
  logic [15:0] imask_q, imask_d;
  logic [15:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic rdy_q, rdy_d;
  logic [63:0] cap_src;
  logic [63:0] cap_rd;
  logic astop_set;
  logic cap_done_ev;
  logic timed_out;

  // command engine: stop issue and response evaluation
  always_comb begin
    st_d = st_q;
    status_d = status_q;
    to_d = to_q;
    timed_out = 1'b0;
    unique case (st_q)
      ACR_IDLE: begin
        if (stop_due && xfer_started) begin
          if (prior_error) begin
            status_d[acr_pkg::B_NOT_EXEC] = 1'b1;
          end else if (stop_issued) begin
            status_d[acr_pkg::B_NOT_EXEC] = 1'b0;
            to_d = TO_CNT;
            st_d = ACR_WAIT_RESP;
          end
        end
        // stop never needed when the transfer never began
      end
      ACR_WAIT_RESP: begin
        if (resp_end) begin
          // crc and timeout jointly encode line conflict
          status_d[acr_pkg::B_TIMEOUT] = 1'b0;
          status_d[acr_pkg::B_CRC] = resp_crc_err;
          status_d[acr_pkg::B_END] = resp_end_err;
          status_d[acr_pkg::B_INDEX] = resp_index_err;
          st_d = ACR_IDLE;
        end else if (card_clk_tick) begin
          if (to_q == 7'h01) begin
            timed_out = 1'b1;
            status_d[acr_pkg::B_TIMEOUT] = 1'b1;
            status_d[acr_pkg::B_CRC] = resp_crc_err;
            status_d[acr_pkg::B_END] = 1'b0;
            status_d[acr_pkg::B_INDEX] = 1'b0;
            st_d = ACR_IDLE;
          end else begin
            to_d = 7'(to_q - 7'h01);
          end
        end
      end
      default: st_d = ACR_IDLE;
    endcase
    // sample not-issued on a read, never beside a command write
    if (reg_rd && hit(reg_addr, acr_pkg::OFF_ASTOP_STATUS) && !cmd_reg_wr) begin
      status_d[acr_pkg::B_NOT_ISSUED] = non_data_command_pending &&
        (|status_d[acr_pkg::B_INDEX:acr_pkg::B_TIMEOUT]);
    end
    status_d = status_d & acr_pkg::STATUS_MASK;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ACR_IDLE;
      status_q <= acr_pkg::STATUS_RST;
      to_q <= 7'h00;
    end else begin
      st_q <= st_d;
      status_q <= status_d;
      to_q <= to_d;
    end
  end

  // rising edge of bits 4..0 only, not-issued excluded
  assign astop_set = |(status_d[4:0] & ~status_q[4:0]);

  // capability source: straps or nonvolatile load
  always_comb begin
    cap_src = CAP_FIXED;
    cap_src[acr_pkg::B_BUS64] = addr64_desc & bus64;
    if (USE_NVM) begin
      cap_src = nvm_data;
      cap_src[acr_pkg::B_BUS64] = nvm_data[acr_pkg::B_BUS64] & bus64;
    end
    cap_src[27] = 1'b0;
  end

  // load sequence follows the full software reset
  always_comb begin
    cst_d = cst_q;
    cap_done_ev = 1'b0;
    unique case (cst_q)
      ACR_CAP_WAIT: begin
        if (!full_reset && (!USE_NVM || nvm_valid)) begin
          cst_d = ACR_CAP_LOAD;
        end
      end
      ACR_CAP_LOAD: begin
        cst_d = ACR_CAP_DONE;
        cap_done_ev = 1'b1;
      end
      ACR_CAP_DONE: begin
        if (full_reset) begin
          cst_d = ACR_CAP_WAIT;
        end
      end
      default: cst_d = ACR_CAP_WAIT;
    endcase
    if (full_reset) begin
      cst_d = ACR_CAP_WAIT;
    end
  end

  assign cap.load = (cst_q == ACR_CAP_LOAD);
  assign cap.wdata = cap_src;
  // voltage bits 24..26 and bus bit 28 held in the image
  assign cap_rd = cap.rdata & acr_pkg::CAP_MASK;

  // interrupt status, mask and readback
  always_comb begin
    ists_d = ists_q;
    imask_d = imask_q;
    rdy_d = (cst_d == ACR_CAP_DONE);
    if (reg_wr && hit(reg_addr, acr_pkg::OFF_IRQ_STATUS)) begin
      ists_d = ists_q & ~reg_wdata;
    end
    if (reg_wr && hit(reg_addr, acr_pkg::OFF_IRQ_MASK)) begin
      imask_d = reg_wdata & acr_pkg::IRQ_USED;
    end
    // set wins over the write-one clear
    if (astop_set) begin
      ists_d[acr_pkg::IRQ_ASTOP] = 1'b1;
    end
    if (cap_done_ev) begin
      ists_d[acr_pkg::IRQ_CAP_DONE] = 1'b1;
    end
    ists_d = ists_d & acr_pkg::IRQ_USED;
    irq_d = |(ists_d & imask_d);
    rdata_d = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        acr_pkg::OFF_ASTOP_STATUS: rdata_d = status_d;
        acr_pkg::OFF_CAP_W0: rdata_d = cap_rd[15:0];
        acr_pkg::OFF_CAP_W1: rdata_d = cap_rd[31:16];
        acr_pkg::OFF_CAP_W2: rdata_d = cap_rd[47:32];
        acr_pkg::OFF_CAP_W3: rdata_d = cap_rd[63:48];
        acr_pkg::OFF_IRQ_STATUS: rdata_d = ists_q;
        acr_pkg::OFF_IRQ_MASK: rdata_d = imask_q;
        acr_pkg::OFF_CAP_LOAD: rdata_d = {15'h0000, rdy_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cst_q <= ACR_CAP_WAIT;
      ists_q <= 16'h0000;
      imask_q <= acr_pkg::IRQ_MASK_RST;
      rdata_q <= 16'h0000;
      irq_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      cst_q <= cst_d;
      ists_q <= ists_d;
      imask_q <= imask_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      rdy_q <= rdy_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = irq_q;
  assign cap_ready = rdy_q;
endmodule
`default_nettype wire

// file: bench/acr_card.sv
// card-side model: response frames for the stop command
// assumes bench picks answer mode and error pattern before each stop
`timescale 1ns/1ps
`default_nettype none
module acr_card (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control from bench
  input wire logic stop_issued,
  input wire logic [1:0] mode,
  input wire logic [2:0] err,
  // command line side
  output logic card_clk_tick,
  output logic resp_end,
  output logic resp_crc_err,
  output logic resp_end_err,
  output logic resp_index_err
);
  logic [5:0] cnt_q;
  logic busy;
  assign busy = cnt_q != 6'h00;
  // error lines flip outside the frame
  assign {resp_index_err, resp_end_err, resp_crc_err} = busy ? err : ~err;
  // mode 2 never answers
  assign resp_end = (cnt_q == 6'h01) && (mode != 2'h2);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 6'h00;
      card_clk_tick <= 1'b0;
    end else begin
      if (stop_issued) begin
        cnt_q <= (mode == 2'h2) ? 6'h28 : 6'h0c;
      end else if (busy) begin
        cnt_q <= cnt_q - 6'h01;
      end
      // card clock only inside a frame
      card_clk_tick <= busy && !cnt_q[0];
    end
  end
endmodule
`default_nettype wire

// file: bench/acr_chk.sv
// port-level checks of the register bank
// assumes capabilities come from the nonvolatile image
`timescale 1ns/1ps
`default_nettype none
module acr_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // watched ports
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic bus64,
  input wire logic full_reset,
  input wire logic [63:0] nvm_data,
  input wire logic cap_ready,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  a_status_rsvd: assert property (s_rd(8'h3c) |=> reg_rdata[15:8] == 8'h00
    && reg_rdata[6:5] == 2'h0) else $error("status reserved bits set");
  a_notiss_pair: assert property (s_rd(8'h3c) ##1 reg_rdata[7] |->
    reg_rdata[4:1] != 4'h0) else $error("not-issued alone");
  a_cap_hi_zero: assert property ((s_rd(8'h44) or s_rd(8'h46)) |=>
    reg_rdata == 16'h0000) else $error("upper caps nonzero");
  a_cap_w1_rsvd: assert property (s_rd(8'h42) |=> reg_rdata[15:13] == 3'h0
    && !reg_rdata[11] && !reg_rdata[4] && !reg_rdata[2])
    else $error("caps reserved set");
  a_cap_bus64: assert property (s_rd(8'h42) && cap_ready |=> reg_rdata[12]
    == $past(nvm_data[28] && bus64)) else $error("bus64 bit");
  a_cap_before: assert property (reg_rd && reg_addr[7:3] == 5'h08
    && !cap_ready |=> reg_rdata == 16'h0000) else $error("early caps");
  a_cap_hold: assert property (full_reset |=> !cap_ready)
    else $error("ready in reset");
  a_unmapped: assert property (reg_rd && !(reg_addr inside {8'h3c, 8'h40,
    8'h42, 8'h44, 8'h46, 8'h50, 8'h52, 8'h54}) |=> reg_rdata == 16'h0000)
    else $error("unmapped read nonzero");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside slot");
  a_reset_quiet: assert property ($rose(rst_b) |-> !irq && !cap_ready)
    else $error("outputs after reset");
endmodule
bind acr_regs acr_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .bus64(bus64), .full_reset(full_reset), .nvm_data(nvm_data),
  .cap_ready(cap_ready), .irq(irq));
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench of the register bank with a card model
// assumes a short response timeout set by parameter
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, stop_due = 0;
  logic prior_error = 0, xfer_started = 0, stop_issued = 0, bus64 = 0;
  logic pend = 0, full_reset = 1, nvm_valid = 1, cap_ready, irq;
  logic cmd_wr = 0;
  logic tick, rend, rcrc, rendb, ridx;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [63:0] nvm_data = 64'hffff_ffff_ffff_ffff;
  logic [1:0] mode = 2'h0;
  logic [2:0] err = 3'h0;
  int bad_count = 0, comparisons = 0;
  always #2.5 ref_clk = ~ref_clk;
  acr_regs #(.TIMEOUT_CLKS(8), .USE_NVM(1'b1)) dut (.ref_clk(ref_clk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_due(stop_due), .prior_error(prior_error),
    .xfer_started(xfer_started), .stop_issued(stop_issued),
    .card_clk_tick(tick), .resp_end(rend), .resp_crc_err(rcrc),
    .resp_end_err(rendb), .resp_index_err(ridx),
    .non_data_command_pending(pend), .cmd_reg_wr(cmd_wr),
    .addr64_desc(1'b0), .bus64(bus64), .full_reset(full_reset),
    .nvm_valid(nvm_valid), .nvm_data(nvm_data), .cap_ready(cap_ready),
    .irq(irq));
  acr_card card (.ref_clk(ref_clk), .rst_b(rst_b), .stop_issued(stop_issued),
    .mode(mode), .err(err), .card_clk_tick(tick), .resp_end(rend),
    .resp_crc_err(rcrc), .resp_end_err(rendb), .resp_index_err(ridx));
  task cmp(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, e);
  endtask
  task stop(input logic pe, input logic xs);
    @(posedge ref_clk);
    stop_due <= 1'b1;
    prior_error <= pe;
    xfer_started <= xs;
    stop_issued <= !pe && xs;
    @(posedge ref_clk);
    stop_due <= 1'b0;
    stop_issued <= 1'b0;
    repeat (50) @(posedge ref_clk);
  endtask
  task t_caps;
    rchk(8'h42, 16'h0000);
    full_reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    cmp({15'h0, cap_ready}, 16'h0001);
    rchk(8'h42, 16'h07eb);
    wr(8'h42, 16'h0000);
    rchk(8'h42, 16'h07eb);
    rchk(8'h44, 16'h0000);
    rchk(8'h12, 16'h0000);
    // strap change only lands through a reload
    bus64 <= 1'b1;
    full_reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    full_reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rchk(8'h42, 16'h17eb);
    $display("test caps done");
  endtask
  task t_not_exec;
    wr(8'h50, 16'h0003);
    wr(8'h52, 16'h0001);
    stop(1'b1, 1'b1);
    rchk(8'h3c, 16'h0001);
    cmp({15'h0, irq}, 16'h0001);
    wr(8'h52, 16'h0000);
    cmp({15'h0, irq}, 16'h0000);
    wr(8'h52, 16'h0001);
    wr(8'h50, 16'h0001);
    cmp({15'h0, irq}, 16'h0000);
    stop(1'b0, 1'b1);
    rchk(8'h3c, 16'h0000);
    wr(8'h50, 16'h0001);
    stop(1'b1, 1'b0);
    rchk(8'h3c, 16'h0000);
    cmp({15'h0, irq}, 16'h0000);
    $display("test not-executed done");
  endtask
  task t_errors;
    for (int i = 0; i < 8; i++) begin
      err <= 3'(i);
      stop(1'b0, 1'b1);
      rchk(8'h3c, {11'h0, err, 2'h0});
    end
    cmp({15'h0, irq}, 16'h0001);
    mode <= 2'h2;
    err <= 3'h0;
    stop(1'b0, 1'b1);
    rchk(8'h3c, 16'h0002);
    err <= 3'h1;
    stop(1'b0, 1'b1);
    rchk(8'h3c, 16'h0006);
    $display("test response errors done");
  endtask
  task t_not_issued;
    wr(8'h50, 16'h0001);
    pend <= 1'b1;
    rchk(8'h3c, 16'h0086);
    cmp({15'h0, irq}, 16'h0000);
    pend <= 1'b0;
    rchk(8'h3c, 16'h0006);
    pend <= 1'b1;
    cmd_wr <= 1'b1;
    rchk(8'h3c, 16'h0006);
    cmd_wr <= 1'b0;
    pend <= 1'b0;
    $display("test not-issued done");
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    final_report;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_caps;
    t_not_exec;
    t_errors;
    t_not_issued;
    final_report;
  end
endmodule
`default_nettype wire
